// >>> rtl/power_transfer_sequencer.sv
/*
 * sequencer for a generator-backed transfer switch: engine start, warmup,
 * neutral hold, transfer, return delay, cooldown, plus weekly exerciser.
 * assumes all contact and sensor inputs are clean levels synchronous to core_clk.
 */
module power_transfer_sequencer
   import xfer_pkg::*;
(
   input  wire logic             core_clk,                 // 25 MHz system clock
   input  wire logic             rst_n,                    // sync reset, active low
   input  wire logic             utility_failed,           // from utility sensor board
   input  wire logic             gen_volt_ok,              // generator voltage >= 80 %
   input  wire logic             gen_freq_ok,              // generator frequency >= 80 %
   input  wire logic             quick_test,               // quick test contact closed
   input  wire logic             standard_test,            // standard test contact closed
   input  wire logic             ext_exercise,             // external exercise timer request
   input  wire logic             exercise_fast,            // test jumper: fast exerciser
   input  wire logic             exercise_transfer,        // move load during exercise
   input  wire logic             neutral_bypass,           // skip neutral hold
   input  wire logic             warmup_bypass,            // skip warmup
   input  wire logic             return_bypass,            // skip return delay
   input  wire logic             pre_move_fitted,          // pre-transfer option fitted
   input  wire logic [PRE_W-1:0] pre_move_secs,            // pre-transfer time, seconds
   input  wire logic             phase_match_fitted,       // in-phase variant fitted
   input  wire logic             utility_in_phase,         // utility in phase with generator
   output logic                  engine_start,             // start contact closed
   output logic                  load_move_relay_drive,    // transfer relay coil to ground
   output logic                  neutral_hold_relay_drive, // neutral relay coil to ground
   output logic                  pre_move_relay_drive,     // pre-transfer relay
   output logic                  exercise_active           // exercise run in progress
);
   seq_state_type state_reg, state_next;
   seq_state_type pre_target_reg;
   logic          tick;
   logic          load_seq, load_run, load_week;
   logic          week_armed_reg, week_fire;
   logic [TMR_W-1:0] seq_value;
   logic          seq_done, run_done, week_done;
   logic          quick_reg, quick_prev_reg, std_prev_reg;
   logic          demand, gen_ok, ret_ready;
   logic          pre_load;

   ////////////////////////////////////////////////////////////////////////////
   second_tick u_tick (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .tick     (tick)
   );

   // single sequencing timer shared by all state intervals
   sec_timer u_seq (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .tick     (tick),
      .load     (load_seq),
      .value    (seq_value),
      .done     (seq_done)
   );

   sec_timer u_run (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .tick     (tick),
      .load     (load_run),
      .value    (MINRUN_T),
      .done     (run_done)
   );

   // weekly exerciser, jumper selects fast rate
   sec_timer u_week (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .tick     (tick),
      .load     (load_week),
      .value    (exercise_fast ? WEEK_FAST_T : WEEK_T),
      .done     (week_done)
   );

   logic [TMR_W-1:0] exer_cnt_reg;
   logic [TMR_W-1:0] quick_cnt_reg;

   ////////////////////////////////////////////////////////////////////////////
   // exercise run window: armed each week, also held by the external timer
   // the week timer leaves reset at zero; arming it first keeps power-up from
   // looking like a due exercise run
   always_ff @(posedge core_clk) begin
      if (!rst_n)
         week_armed_reg <= 1'b0;
      else
         week_armed_reg <= 1'b1;
   end

   assign week_fire = week_armed_reg && week_done;
   assign load_week = week_fire || !week_armed_reg;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         exer_cnt_reg    <= TMR_ZERO;
         exercise_active <= 1'b0;
      end else begin
         if (week_fire)
            exer_cnt_reg <= EXER_T;
         else if (tick && exer_cnt_reg != TMR_ZERO)
            exer_cnt_reg <= exer_cnt_reg - TMR_ONE;
         exercise_active <= ext_exercise || week_fire || (exer_cnt_reg != TMR_ZERO);
      end
   end

   // quick test starts on contact closure, runs a fixed time
   // standard test runs while its contact stays closed
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         quick_prev_reg <= 1'b0;
         std_prev_reg   <= 1'b0;
         quick_reg      <= 1'b0;
         quick_cnt_reg  <= TMR_ZERO;
      end else begin
         quick_prev_reg <= quick_test;
         std_prev_reg   <= standard_test;
         if (quick_test && !quick_prev_reg) begin
            quick_cnt_reg <= QUICK_T;
            quick_reg     <= 1'b1;
         end else if (tick && quick_cnt_reg != TMR_ZERO) begin
            quick_cnt_reg <= quick_cnt_reg - TMR_ONE;
         end else if (quick_cnt_reg == TMR_ZERO) begin
            quick_reg <= 1'b0;
         end
      end
   end

   // utility failure is the main trigger; tests and exercise add to it
   assign demand = utility_failed || quick_reg || std_prev_reg
                   || (exercise_active && exercise_transfer);
   // both generator sensors must be satisfied
   assign gen_ok = gen_volt_ok && gen_freq_ok;
   // in-phase variant waits for phase agreement before returning
   assign ret_ready = !phase_match_fitted || utility_in_phase;
   assign pre_load  = pre_move_fitted && (pre_move_secs != '0);

   ////////////////////////////////////////////////////////////////////////////
   // next state and interval loads
   always_comb begin
      state_next = state_reg;
      load_seq   = 1'b0;
      seq_value  = TMR_ZERO;
      load_run   = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            if (demand || exercise_active) begin
               state_next = ST_WARMUP;
               load_seq   = 1'b1;
               seq_value  = warmup_bypass ? TMR_ZERO : WARMUP_T;
               load_run   = 1'b1;
            end
         end
         ST_WARMUP: begin
            if (!demand && !exercise_active) begin
               state_next = ST_COOLDOWN;
            end else if (demand && seq_done && gen_ok) begin
               load_seq = 1'b1;
               if (pre_load) begin
                  state_next = ST_PRE_MOVE;
                  seq_value  = TMR_W'(pre_move_secs);
               end else begin
                  // bypass goes straight onto the generator
                  state_next = neutral_bypass ? ST_ON_GEN : ST_NEUT_GEN;
                  seq_value  = NEUTRAL_T;
               end
            end
         end
         ST_PRE_MOVE: begin
            if (seq_done) begin
               load_seq = 1'b1;
               if (pre_target_reg == ST_NEUT_UTL) begin
                  state_next = neutral_bypass ? ST_COOLDOWN : ST_NEUT_UTL;
                  seq_value  = neutral_bypass ? COOLDOWN_T : NEUTRAL_T;
               end else begin
                  state_next = neutral_bypass ? ST_ON_GEN : ST_NEUT_GEN;
                  seq_value  = NEUTRAL_T;
               end
            end
         end
         ST_NEUT_GEN: begin
            if (seq_done)
               state_next = ST_ON_GEN;
         end
         ST_ON_GEN: begin
            if (!demand) begin
               state_next = ST_RET_WAIT;
               load_seq   = 1'b1;
               seq_value  = RETURN_T;
            end
         end
         ST_RET_WAIT: begin
            // return delay, bypass input skips it
            if (demand) begin
               state_next = ST_ON_GEN;
            end else if ((seq_done || return_bypass) && ret_ready) begin
               load_seq = 1'b1;
               if (pre_load) begin
                  state_next = ST_PRE_MOVE;
                  seq_value  = TMR_W'(pre_move_secs);
               end else begin
                  // bypass lands straight in cooldown on utility
                  state_next = neutral_bypass ? ST_COOLDOWN : ST_NEUT_UTL;
                  seq_value  = neutral_bypass ? COOLDOWN_T : NEUTRAL_T;
               end
            end
         end
         ST_NEUT_UTL: begin
            if (seq_done) begin
               state_next = ST_COOLDOWN;
               load_seq   = 1'b1;
               seq_value  = COOLDOWN_T;
            end
         end
         ST_COOLDOWN: begin
            // cooldown and minimum run before stop
            if (demand) begin
               state_next = ST_WARMUP;
               load_seq   = 1'b1;
               seq_value  = TMR_ZERO;
            end else if (seq_done && run_done) begin
               state_next = ST_IDLE;
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n)
         state_reg <= ST_IDLE;
      else
         state_reg <= state_next;
   end

   // remembers which way a pre-transfer signal is heading
   always_ff @(posedge core_clk) begin
      if (!rst_n)
         pre_target_reg <= ST_NEUT_GEN;
      else if (state_reg == ST_RET_WAIT)
         pre_target_reg <= ST_NEUT_UTL;
      else if (state_reg == ST_WARMUP)
         pre_target_reg <= ST_NEUT_GEN;
   end

   ////////////////////////////////////////////////////////////////////////////
   // registered outputs decoded from the next state
   // drive outputs
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         engine_start             <= 1'b0;
         load_move_relay_drive    <= 1'b0;
         neutral_hold_relay_drive <= 1'b0;
         pre_move_relay_drive     <= 1'b0;
      end else begin
         engine_start             <= (state_next != ST_IDLE);
         neutral_hold_relay_drive <= (state_next == ST_NEUT_GEN) || (state_next == ST_NEUT_UTL);
         pre_move_relay_drive     <= (state_next == ST_PRE_MOVE);
         load_move_relay_drive    <= (state_next == ST_ON_GEN) || (state_next == ST_RET_WAIT)
                                     || (state_next == ST_NEUT_GEN)
                                     || (state_next == ST_PRE_MOVE && state_reg != ST_WARMUP
                                         && (state_reg == ST_RET_WAIT || pre_target_reg == ST_NEUT_UTL));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   a_gen_ok_move: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state_reg == ST_WARMUP && state_next != ST_WARMUP && state_next != ST_COOLDOWN) |-> gen_ok)
      else $error("transfer to generator without good voltage and frequency");
   a_reset_idle: assert property (@(posedge core_clk)
      !rst_n |=> (state_reg == ST_IDLE && !engine_start && !load_move_relay_drive))
      else $error("reset did not clear outputs");
   a_start_while_run: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state_reg != ST_IDLE) |-> engine_start)
      else $error("engine start open while sequencer busy");
   a_neutral_begin: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state_reg == ST_NEUT_GEN || state_reg == ST_NEUT_UTL) |-> neutral_hold_relay_drive)
      else $error("neutral drive not asserted in neutral hold");
   a_neutral_end: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state_reg == ST_ON_GEN || state_reg == ST_COOLDOWN) |-> !neutral_hold_relay_drive)
      else $error("neutral drive left on after hold");
   a_move_on_gen: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state_reg == ST_ON_GEN) |-> load_move_relay_drive)
      else $error("load move drive off while on generator");
   a_move_return: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state_reg == ST_COOLDOWN || state_reg == ST_IDLE) |-> !load_move_relay_drive)
      else $error("load move drive on after return");
   a_cooldown_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state_reg == ST_COOLDOWN && !seq_done) |=> state_reg != ST_IDLE)
      else $error("engine stopped before cooldown ended");
   a_pre_only_fitted: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(pre_move_relay_drive) |-> $past(pre_move_fitted))
      else $error("pre-transfer signal without option");
   a_bypass_no_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      (neutral_bypass && !neutral_hold_relay_drive) |=> !neutral_hold_relay_drive)
      else $error("neutral hold entered with bypass set");
endmodule // power_transfer_sequencer

// >>> rtl/sec_timer.sv
/*
 * loadable down-counter of seconds; done is high while the count is zero.
 * assumes a one-cycle tick enable; load wins over counting.
 */
module sec_timer
   import xfer_pkg::*;
(
   input  wire logic             core_clk,  // system clock
   input  wire logic             rst_n,     // sync reset, active low
   input  wire logic             tick,      // one second enable
   input  wire logic             load,      // load a new interval
   input  wire logic [TMR_W-1:0] value,     // interval in seconds
   output logic                  done       // interval elapsed
);
   logic [TMR_W-1:0] cnt_reg;

   always_ff @(posedge core_clk) begin
      if (!rst_n)
         cnt_reg <= TMR_ZERO;
      else if (load)
         cnt_reg <= value;
      else if (tick && cnt_reg != TMR_ZERO)
         cnt_reg <= cnt_reg - TMR_ONE;
   end

   // done must not look at load: the sequencer derives load from done, so a
   // load term here would close a combinational loop through the state logic
   assign done = (cnt_reg == TMR_ZERO);
endmodule // sec_timer

// >>> rtl/second_tick.sv
/*
 * prescaler: one-cycle enable pulse once a second from the core clock.
 * assumes core_clk at the rate given in the package.
 */
module second_tick
   import xfer_pkg::*;
(
   input  wire logic core_clk,   // system clock
   input  wire logic rst_n,      // sync reset, active low
   output logic      tick        // one-cycle pulse per second
);
   logic [PRESC_W-1:0] cnt_reg;

   ////////////////////////////////////////////////////////////////////////////
   // one second prescaler
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cnt_reg <= '0;
         tick    <= 1'b0;
      end else if (cnt_reg == PRESC_W'(TICK_CYCLES - 1)) begin
         cnt_reg <= '0;
         tick    <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + PRESC_W'(1);
         tick    <= 1'b0;
      end
   end
endmodule // second_tick

// >>> rtl/xfer_pkg.sv
/*
 * constants, state type and timing figures for the power transfer sequencer.
 * assumes a single 25 MHz core clock and plain level inputs from contacts and sensor boards.
 */
package xfer_pkg;
   localparam int unsigned CLK_HZ        = 25_000_000;
   localparam int unsigned TICK_CYCLES   = CLK_HZ;            // one second
   localparam int unsigned PRESC_W       = 25;
   localparam int unsigned TMR_W         = 20;
   localparam int unsigned COOLDOWN_MIN  = 10;
   localparam int unsigned MINRUN_MIN    = 10;
   localparam int unsigned WARMUP_S      = 30;
   localparam int unsigned RETURN_S      = 30;
   localparam int unsigned NEUTRAL_S     = 5;
   localparam int unsigned QUICK_TEST_S  = 60;                // quick test run length
   localparam int unsigned WEEK_S        = 7 * 24 * 3600;
   localparam int unsigned WEEK_FAST_S   = 7 * 60;            // jumper rate
   localparam int unsigned EXER_RUN_S    = 20 * 60;           // exercise run length
   localparam logic [TMR_W-1:0] COOLDOWN_T = TMR_W'(COOLDOWN_MIN * 60);
   localparam logic [TMR_W-1:0] MINRUN_T   = TMR_W'(MINRUN_MIN * 60);
   localparam logic [TMR_W-1:0] WARMUP_T   = TMR_W'(WARMUP_S);
   localparam logic [TMR_W-1:0] RETURN_T   = TMR_W'(RETURN_S);
   localparam logic [TMR_W-1:0] NEUTRAL_T  = TMR_W'(NEUTRAL_S);
   localparam logic [TMR_W-1:0] QUICK_T    = TMR_W'(QUICK_TEST_S);
   localparam logic [TMR_W-1:0] WEEK_T     = TMR_W'(WEEK_S);
   localparam logic [TMR_W-1:0] WEEK_FAST_T = TMR_W'(WEEK_FAST_S);
   localparam logic [TMR_W-1:0] EXER_T     = TMR_W'(EXER_RUN_S);
   localparam logic [TMR_W-1:0] TMR_ZERO   = 20'h0_0000;
   localparam logic [TMR_W-1:0] TMR_ONE    = 20'h0_0001;
   localparam int unsigned PRE_W         = 8;

   // gray codes along start, warmup, neutral, on gen, return, neutral, cooldown
   typedef enum logic [2:0] {
      ST_IDLE     = 3'b000,
      ST_WARMUP   = 3'b001,
      ST_NEUT_GEN = 3'b011,
      ST_ON_GEN   = 3'b010,
      ST_RET_WAIT = 3'b110,
      ST_NEUT_UTL = 3'b111,
      ST_COOLDOWN = 3'b101,
      ST_PRE_MOVE = 3'b100
   } seq_state_type;
endpackage

// >>> verification/gen_sensor_model.sv
/*
 * far side model: engine-generator set and its voltage and frequency sensors.
 * assumes the start contact is a level from the sequencer; bench may hold the set weak.
 */
module gen_sensor_model #(
   parameter int SPIN_UP = 4            // cycles from start contact to rated output
) (
   input  wire logic core_clk,          // system clock
   input  wire logic rst_n,             // sync reset, active low
   input  wire logic engine_start,      // start contact from sequencer
   input  wire logic gen_fault,         // bench: keep output below 80 percent
   output logic      gen_volt_ok,       // voltage at or above 80 percent
   output logic      gen_freq_ok        // frequency at or above 80 percent
);
   timeunit 1ns;
   timeprecision 1ns;
   int run_cnt;

   ////////////////////////////////////////////////////////////////////////////
   // engine runs only while the contact stays closed
   always_ff @(posedge core_clk) begin
      if (!rst_n || !engine_start) begin
         run_cnt <= 0;
      end else if (run_cnt < SPIN_UP) begin
         run_cnt <= run_cnt + 1;
      end
   end

   // sensors report rated output late
   // a stopped or weak set reads as not ready, never as the last value
   assign gen_volt_ok = (run_cnt >= SPIN_UP) && !gen_fault;
   assign gen_freq_ok = (run_cnt >= SPIN_UP) && !gen_fault;
endmodule // gen_sensor_model

// >>> verification/power_transfer_sequencer_tb.sv
/*
 * self-checking bench for the transfer sequencer: one task per scenario.
 * assumes the one second tick never arrives within the run, so only the
 * starts of intervals and everything that skips them are observable.
 */
module power_transfer_sequencer_tb
   import xfer_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk, rst_n, utility_failed, quick_test, standard_test, ext_exercise;
   logic exercise_fast, exercise_transfer, neutral_bypass, warmup_bypass, return_bypass;
   logic pre_move_fitted, phase_match_fitted, utility_in_phase, gen_fault;
   logic [PRE_W-1:0] pre_move_secs;
   logic engine_start, load_move_relay_drive, neutral_hold_relay_drive, pre_move_relay_drive;
   logic exercise_active, gen_volt_ok, gen_freq_ok;
   int   n_fail, n_compared;
   bit   saw_neutral;

   power_transfer_sequencer uut (.core_clk(core_clk), .rst_n(rst_n), .utility_failed(utility_failed),
      .gen_volt_ok(gen_volt_ok), .gen_freq_ok(gen_freq_ok), .quick_test(quick_test),
      .standard_test(standard_test), .ext_exercise(ext_exercise), .exercise_fast(exercise_fast),
      .exercise_transfer(exercise_transfer), .neutral_bypass(neutral_bypass),
      .warmup_bypass(warmup_bypass), .return_bypass(return_bypass), .pre_move_fitted(pre_move_fitted),
      .pre_move_secs(pre_move_secs), .phase_match_fitted(phase_match_fitted),
      .utility_in_phase(utility_in_phase), .engine_start(engine_start),
      .load_move_relay_drive(load_move_relay_drive), .neutral_hold_relay_drive(neutral_hold_relay_drive),
      .pre_move_relay_drive(pre_move_relay_drive), .exercise_active(exercise_active));
   gen_sensor_model gen (.core_clk(core_clk), .rst_n(rst_n), .engine_start(engine_start),
      .gen_fault(gen_fault), .gen_volt_ok(gen_volt_ok), .gen_freq_ok(gen_freq_ok));

   ////////////////////////////////////////////////////////////////////////////
   // 25 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   // any neutral hold pulse is remembered for the bypass scenario
   always @(posedge core_clk) if (neutral_hold_relay_drive === 1'b1) saw_neutral = 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // shared helpers; inputs change 1 ns after the rising edge
   task step(input int n);
      repeat (n) begin
         @(posedge core_clk);
         #1;
      end
   endtask

   task chk(input bit ok, input string msg);
      n_compared++;
      if (!ok) begin
         n_fail++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask

   function automatic logic pick(input int sel);
      case (sel)
         0: return engine_start;
         1: return load_move_relay_drive;
         2: return neutral_hold_relay_drive;
         default: return pre_move_relay_drive;
      endcase
   endfunction

   // bounded wait for an output level
   task wait_out(input int sel, input logic val, input int lim, input string msg);
      bit hit;
      hit = 1'b0;
      for (int i = 0; i < lim && !hit; i++) begin
         step(1);
         if (pick(sel) === val) hit = 1'b1;
      end
      chk(hit, msg);
   endtask

   // output must keep one level for n cycles
   task hold_out(input int sel, input logic val, input int n, input string msg);
      bit ok;
      ok = 1'b1;
      for (int i = 0; i < n; i++) begin
         step(1);
         if (pick(sel) !== val) ok = 1'b0;
      end
      chk(ok, msg);
   endtask

   // reset with all inputs quiet, then all drives must be open
   task apply_reset();
      {rst_n, utility_failed, quick_test, standard_test, ext_exercise, exercise_fast} = 6'h00;
      {exercise_transfer, neutral_bypass, warmup_bypass, return_bypass} = 4'h0;
      {pre_move_fitted, phase_match_fitted, utility_in_phase, gen_fault} = 4'h0;
      pre_move_secs = 8'h00;
      step(8);
      rst_n = 1'b1;
      // cleared only now: the first reset edge still shows a hold left from the last scenario
      saw_neutral = 1'b0;
      step(1);
      chk({engine_start, load_move_relay_drive, neutral_hold_relay_drive, pre_move_relay_drive,
           exercise_active} === 5'h00, "outputs not idle after reset");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   task t_refused_then_move();
      warmup_bypass = 1'b1;
      gen_fault = 1'b1;
      utility_failed = 1'b1;
      wait_out(0, 1'b1, 2, "start contact late");
      hold_out(1, 1'b0, 50, "moved onto weak generator");
      gen_fault = 1'b0;
      wait_out(2, 1'b1, 20, "no neutral hold on transfer");
      wait_out(1, 1'b1, 20, "load move drive not set");
      hold_out(2, 1'b1, 100, "neutral hold ended early");
      apply_reset();
   endtask

   task t_bypass_return();
      {neutral_bypass, warmup_bypass} = 2'b11;
      utility_failed = 1'b1;
      wait_out(1, 1'b1, 30, "no move with bypasses");
      return_bypass = 1'b1;
      utility_failed = 1'b0;
      wait_out(1, 1'b0, 20, "return delay not skipped");
      chk(!saw_neutral, "neutral hold despite bypass");
      hold_out(0, 1'b1, 50, "engine stopped without cooldown");
      apply_reset();
   endtask

   task t_warmup();
      utility_failed = 1'b1;
      wait_out(0, 1'b1, 2, "no start on failure");
      hold_out(1, 1'b0, 200, "moved during warmup");
      apply_reset();
   endtask

   task t_pre_move();
      {pre_move_fitted, warmup_bypass} = 2'b11;
      pre_move_secs = 8'h03;
      utility_failed = 1'b1;
      wait_out(3, 1'b1, 20, "no pre move signal");
      hold_out(1, 1'b0, 100, "moved before pre move time");
      apply_reset();
   endtask

   task t_phase();
      {phase_match_fitted, neutral_bypass, warmup_bypass} = 3'b111;
      utility_failed = 1'b1;
      wait_out(1, 1'b1, 30, "no move in phase variant");
      return_bypass = 1'b1;
      utility_failed = 1'b0;
      hold_out(1, 1'b1, 100, "returned out of phase");
      utility_in_phase = 1'b1;
      wait_out(1, 1'b0, 20, "no return when in phase");
      apply_reset();
   endtask

   // operator contacts and external exerciser each start the engine
   task t_demands();
      for (int k = 0; k < 3; k++) begin
         case (k)
            0: quick_test = 1'b1;
            1: standard_test = 1'b1;
            default: {exercise_fast, ext_exercise} = 2'b11;
         endcase
         wait_out(0, 1'b1, 5, "demand did not start engine");
         if (k == 2) chk(exercise_active === 1'b1, "exercise request not shown");
         apply_reset();
      end
   endtask

   task end_of_test();
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      n_fail = 0;
      n_compared = 0;
      apply_reset();
      t_refused_then_move();
      t_bypass_return();
      t_warmup();
      t_pre_move();
      t_phase();
      t_demands();
      end_of_test();
   end

   // watchdog: the run needs well under 2000 cycles
   initial begin
      #400_000;
      n_fail++;
      $display("mismatch at %0t: watchdog expired", $time);
      end_of_test();
   end
endmodule // power_transfer_sequencer_tb
